// file: verilog/ddcl_front.sv
// Down-converter output formatting, decimation and serial link framing.
// Assumes APB master on mclk; syncN and sysref are asynchronous pins.
`timescale 1ns/1ns
module ddcl_front
    import ddcl_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire ddcl_pkg::ddcl_iq_t sampleIn,
    input  wire logic             sampleValid,
    input  wire logic             syncN,
    input  wire logic             sysref,
    output ddcl_pkg::ddcl_out_t   outWord,
    output ddcl_pkg::ddcl_lane_t  lanes [ddcl_pkg::LANES_MAX],
    output logic                  fecOn,
    output logic                  ncoSyncTrig
);
    import ddcl_pkg::*;

    logic [31:0]      ctrl_reg, ctrl_next;
    logic [7:0]       frame_reg, frame_next;
    logic [31:0]      rdata_reg, rdata_next;
    logic             errHit;
    logic [2:0]       syncSh_reg, syncSh_next;
    logic [2:0]       refSh_reg, refSh_next;
    logic [7:0]       lmfc_reg, lmfc_next;
    logic [1:0]       mf_reg, mf_next;
    ddcl_link_t       state_reg, state_next;
    logic signed [ACC_W-1:0] accI_reg, accI_next, accQ_reg, accQ_next;
    logic [4:0]       dec_reg, dec_next;
    logic             ovA_reg, ovA_next, ovB_reg, ovB_next;
    ddcl_out_t        out_reg, out_next;
    ddcl_lane_t       lane_reg [LANES_MAX];
    ddcl_lane_t       lane_next [LANES_MAX];
    logic             nco_reg, nco_next;

    ddcl_mode_t mode;
    logic boost, enc64, linkEn, access, syncLvl, syncRise, syncFall, refRise, mfEdge;
    logic [4:0] laneCnt;
    logic [2:0] shift;
    logic [4:0] decLast;
    logic signed [ACC_W-1:0] sumI, sumQ;
    logic [15:0] scaledI, scaledQ;

    // Saturating scale of a window sum to 16 bits
    function automatic logic [15:0] scale(input logic signed [ACC_W-1:0] s,
                                          input logic [2:0] sh);
        logic signed [ACC_W-1:0] v;
        v = s >>> sh;
        if (v > 21'sd32767) scale = 16'h7FFF;
        else if (v < -21'sd32768) scale = 16'h8000;
        else scale = v[15:0];
    endfunction

    assign mode    = ddcl_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 3]);
    assign boost   = ctrl_reg[CTRL_BOOST_BIT];
    assign enc64   = ctrl_reg[CTRL_ENC64_BIT];
    assign linkEn  = ctrl_reg[CTRL_EN_BIT];
    assign laneCnt = ctrl_reg[CTRL_LANES_LSB +: 5];
    assign access  = psel & penable;
    // Only the second and third flops are read; the first is left alone
    assign syncLvl  = syncSh_reg[1];
    assign syncRise = syncSh_reg[1] & ~syncSh_reg[2];
    assign syncFall = ~syncSh_reg[1] & syncSh_reg[2];
    assign refRise  = refSh_reg[1] & ~refSh_reg[2];
    assign mfEdge   = (lmfc_reg == frame_reg);
    assign fecOn    = enc64 & ctrl_reg[CTRL_FEC_BIT];
    assign ncoSyncTrig = nco_reg;
    assign outWord  = out_reg;
    assign prdata   = rdata_reg;
    assign pready   = 1'b1;
    // Combinational so the error stands beside pready in the access phase
    assign pslverr  = errHit;

    // Register file; writes commit at the access phase
    always_comb begin
        ctrl_next  = ctrl_reg;
        frame_next = frame_reg;
        rdata_next = rdata_reg;
        errHit     = 1'b0;
        if (psel & ~penable) begin
            rdata_next = 32'h0000_0000;
            case (paddr)
                ADDR_CTRL:  rdata_next = ctrl_reg;
                ADDR_FRAME: rdata_next = {24'h00_0000, frame_reg};
                ADDR_STAT:  rdata_next = {20'h0_0000, mf_reg, lmfc_reg[4:0],
                                          syncLvl, 1'b0, state_reg};
                default:    rdata_next = 32'h0000_0000;
            endcase
        end
        if (access) begin
            case (paddr)
                ADDR_CTRL:  if (pwrite) ctrl_next = pwdata & 32'h0001_F1F7;
                ADDR_FRAME: if (pwrite) frame_next = pwdata[7:0];
                ADDR_STAT:  errHit = pwrite;
                default:    errHit = 1'b1;
            endcase
        end
    end

    // Decimation by window sum; 6.02 dB boost drops one shift step
    always_comb begin
        case (mode)
            MODE_DEC4:  begin shift = 3'h2; decLast = 5'h03; end
            MODE_DEC8:  begin shift = 3'h3; decLast = 5'h07; end
            MODE_DEC16: begin shift = 3'h4; decLast = 5'h0F; end
            MODE_DEC32: begin shift = 3'h5; decLast = 5'h1F; end
            default:    begin shift = 3'h0; decLast = 5'h00; end
        endcase
        if (boost && mode != MODE_BYPASS) shift = shift - 3'h1;
        sumI = accI_reg + ACC_W'(sampleIn.i);
        sumQ = accQ_reg + ACC_W'(sampleIn.q);
        scaledI = scale(sumI, shift);
        scaledQ = scale(sumQ, shift);
        accI_next = accI_reg;
        accQ_next = accQ_reg;
        dec_next  = dec_reg;
        ovA_next  = ovA_reg;
        ovB_next  = ovB_reg;
        out_next  = out_reg;
        out_next.valid = 1'b0;
        if (sampleValid) begin
            if (mode == MODE_BYPASS || mode > MODE_DEC32) begin
                out_next.iWord = {sampleIn.i[15:1], sampleIn.ovrA};
                out_next.qWord = 16'h0000;
                out_next.complexOut = 1'b0;
                out_next.valid = 1'b1;
            end else if (dec_reg >= decLast) begin
                out_next.iWord = {scaledI[15:1], ovA_reg | sampleIn.ovrA};
                out_next.qWord = {scaledQ[15:1], ovB_reg | sampleIn.ovrB};
                out_next.complexOut = 1'b1;
                out_next.valid = 1'b1;
                accI_next = '0;
                accQ_next = '0;
                dec_next  = 5'h00;
                ovA_next  = 1'b0;
                ovB_next  = 1'b0;
            end else begin
                accI_next = sumI;
                accQ_next = sumQ;
                dec_next  = dec_reg + 5'h01;
                ovA_next  = ovA_reg | sampleIn.ovrA;
                ovB_next  = ovB_reg | sampleIn.ovrB;
            end
        end
    end

    // Multiframe / extended multiblock counter and link state
    always_comb begin
        syncSh_next = {syncSh_reg[1:0], syncN};
        refSh_next  = {refSh_reg[1:0], sysref};
        lmfc_next   = mfEdge ? 8'h00 : lmfc_reg + 8'h01;
        if (refRise) lmfc_next = 8'h00;
        mf_next    = mf_reg;
        state_next = state_reg;
        // Oscillator trigger only; never steers the 64b/66b link
        nco_next = enc64 & ctrl_reg[CTRL_NCOSYN_BIT] & syncFall;
        case (state_reg)
            L_IDLE:    if (linkEn) state_next = enc64 ? L_BLKWAIT : L_CGS;
            L_CGS:     if (syncRise) state_next = L_WAIT;
            L_WAIT:    if (mfEdge) begin
                state_next = L_ILAS;
                mf_next = 2'h0;
            end
            L_ILAS:    if (mfEdge) begin
                mf_next = mf_reg + 2'h1;
                if (mf_reg == ILAS_LAST_MF) state_next = L_DATA;
            end
            L_DATA:    state_next = L_DATA;
            L_BLKWAIT: if (mfEdge) state_next = L_BLK;
            L_BLK:     state_next = L_BLK;
            default:   state_next = L_IDLE;
        endcase
        // A low SYNC restarts code group sync in 8b/10b only
        if (!enc64 && !syncLvl && state_reg inside {L_WAIT, L_ILAS, L_DATA})
            state_next = L_CGS;
        if (!linkEn || (enc64 != (state_reg inside {L_BLKWAIT, L_BLK})
                        && state_reg != L_IDLE))
            state_next = L_IDLE;
    end

    // Lane mapping: in L_DATA and L_BLK, lane n below laneCnt carries octet n mod 4 of the current I/Q pair
    always_comb begin
        logic [31:0] pair;
        pair = {out_reg.iWord, out_reg.qWord};
        for (int n = 0; n < LANES_MAX; n++) begin
            lane_next[n] = '0;
            if (5'(n) < laneCnt) begin
                lane_next[n].octet = pair[8*(3-(n%4)) +: 8];
                case (state_reg)
                    L_CGS, L_WAIT: begin
                        lane_next[n].octet = CHAR_K28_5;
                        lane_next[n].ctrlChar = 1'b1;
                    end
                    L_ILAS: begin
                        // Ramp filler keeps ILAS deterministic per lane
                        lane_next[n].octet = lmfc_reg;
                        if (lmfc_reg == 8'h00) begin
                            lane_next[n].octet = CHAR_K28_0;
                            lane_next[n].ctrlChar = 1'b1;
                        end else if (mfEdge) begin
                            lane_next[n].octet = CHAR_K28_3;
                            lane_next[n].ctrlChar = 1'b1;
                        end
                    end
                    L_BLK:  lane_next[n].header = SH_DATA;
                    L_DATA: lane_next[n].header = 2'h0;
                    default: lane_next[n].octet = 8'h00;
                endcase
            end
        end
    end

    // All state runs on the one device clock
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg   <= CTRL_RESET;
            frame_reg  <= FRAME_RESET;
            rdata_reg  <= 32'h0000_0000;
            // Idle-high reset level, so no false SYNC edge follows reset
            syncSh_reg <= 3'h7;
            refSh_reg  <= 3'h0;
            lmfc_reg   <= 8'h00;
            mf_reg     <= 2'h0;
            state_reg  <= L_IDLE;
            accI_reg   <= '0;
            accQ_reg   <= '0;
            dec_reg    <= 5'h00;
            ovA_reg    <= 1'b0;
            ovB_reg    <= 1'b0;
            out_reg    <= '0;
            nco_reg    <= 1'b0;
            for (int n = 0; n < LANES_MAX; n++) lane_reg[n] <= '0;
        end else begin
            ctrl_reg   <= ctrl_next;
            frame_reg  <= frame_next;
            rdata_reg  <= rdata_next;
            syncSh_reg <= syncSh_next;
            refSh_reg  <= refSh_next;
            lmfc_reg   <= lmfc_next;
            mf_reg     <= mf_next;
            state_reg  <= state_next;
            accI_reg   <= accI_next;
            accQ_reg   <= accQ_next;
            dec_reg    <= dec_next;
            ovA_reg    <= ovA_next;
            ovB_reg    <= ovB_next;
            out_reg    <= out_next;
            nco_reg    <= nco_next;
            for (int n = 0; n < LANES_MAX; n++) lane_reg[n] <= lane_next[n];
        end
    end

    assign lanes = lane_reg;
endmodule // ddcl_front

// file: pkg/ddcl_pkg.sv
// Package for the down-converter output and serial link front.
// Assumes one clock (mclk) and an APB master with 32-bit data.
package ddcl_pkg;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_FRAME  = 12'h004;
    localparam logic [11:0] ADDR_STAT   = 12'h008;
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_BOOST_BIT  = 4;
    localparam int CTRL_ENC64_BIT  = 5;
    localparam int CTRL_FEC_BIT    = 6;
    localparam int CTRL_NCOSYN_BIT = 7;
    localparam int CTRL_EN_BIT     = 8;
    localparam int CTRL_LANES_LSB  = 12;
    localparam logic [31:0] CTRL_RESET  = 32'h0001_0000;
    localparam logic [7:0]  FRAME_RESET = 8'h1F;
    localparam int LANES_MAX = 16;
    localparam logic [4:0] LANES_RESET = 5'h10;
    localparam logic [1:0] ILAS_LAST_MF = 2'h3;
    localparam logic [7:0] CHAR_K28_5 = 8'hBC;
    localparam logic [7:0] CHAR_K28_0 = 8'h1C;
    localparam logic [7:0] CHAR_K28_3 = 8'h7C;
    localparam logic [1:0] SH_DATA = 2'h1;
    localparam int ACC_W = 21;
    typedef enum logic [2:0] {MODE_BYPASS, MODE_DEC4, MODE_DEC8, MODE_DEC16, MODE_DEC32} ddcl_mode_t;
    typedef enum logic [2:0] {L_IDLE, L_CGS, L_WAIT, L_ILAS, L_DATA, L_BLKWAIT, L_BLK} ddcl_link_t;
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
        logic               ovrA;
        logic               ovrB;
    } ddcl_iq_t;
    typedef struct packed {
        logic [15:0] iWord;
        logic [15:0] qWord;
        logic        complexOut;
        logic        valid;
    } ddcl_out_t;
    typedef struct packed {
        logic [1:0] header;
        logic       ctrlChar;
        logic [7:0] octet;
    } ddcl_lane_t;
endpackage

// file: dv/ddcl_front_properties.sv
// Port-level checker for ddcl_front.
// Assumes CTRL writes land at the APB access edge and sees only top ports.
`timescale 1ns/1ns
module ddcl_front_properties (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire ddcl_pkg::ddcl_iq_t   sampleIn,
    input wire logic                 sampleValid,
    input wire logic                 syncN,
    input wire ddcl_pkg::ddcl_out_t  outWord,
    input wire ddcl_pkg::ddcl_lane_t lanes [ddcl_pkg::LANES_MAX],
    input wire logic                 fecOn,
    input wire logic                 ncoSyncTrig
);
    import ddcl_pkg::*;
    logic [31:0] ctrlReg, ctrlNext;
    logic [2:0]  quietReg, quietNext;
    logic        ctrlWr, byp, quiet;
    logic [15:0] bypWord;
    // Shadow of CTRL; quiet guards against the pipeline lag after a write
    always_comb begin
        ctrlWr    = psel && penable && pwrite && pready && (paddr == ADDR_CTRL);
        ctrlNext  = rst ? CTRL_RESET : (ctrlWr ? (pwdata & 32'h0001_F1F7) : ctrlReg);
        quietNext = (rst || ctrlWr) ? 3'h0 : quietReg + {2'h0, quietReg != 3'h7};
        byp       = (ctrlReg[2:0] == 3'h0) || (ctrlReg[2:0] > 3'h4);
        quiet     = quietReg == 3'h7;
        bypWord   = {sampleIn.i[15:1], sampleIn.ovrA};
    end
    always_ff @(posedge mclk) begin
        ctrlReg  <= ctrlNext;
        quietReg <= quietNext;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_FEC_ON: assert property (fecOn == (ctrlReg[CTRL_ENC64_BIT] && ctrlReg[CTRL_FEC_BIT]))
        else $error("fecOn does not follow encoding and FEC bits");
    AST_NCO_TRIG: assert property (ncoSyncTrig && quietReg != 3'h0 |->
        ctrlReg[CTRL_ENC64_BIT] && ctrlReg[CTRL_NCOSYN_BIT]) else $error("stray NCO trigger");
    AST_BYP_REAL: assert property (outWord.valid && byp && quiet |->
        !outWord.complexOut && outWord.qWord == 16'h0000) else $error("bypass output not real");
    AST_BYP_WORD: assert property (byp && quiet && sampleValid |=>
        outWord.valid && outWord.iWord == $past(bypWord)) else $error("bypass word wrong");
    AST_CPLX: assert property (outWord.valid && !byp && quiet |-> outWord.complexOut)
        else $error("decimated output not complex");
    AST_VALID_CAUSE: assert property (outWord.valid |-> $past(sampleValid))
        else $error("output without a taken sample");
    AST_CGS_COMMA: assert property ((ctrlReg[CTRL_EN_BIT] && !ctrlReg[CTRL_ENC64_BIT]
        && !syncN && quiet && ctrlReg[16:12] != 5'h00)[*6] |->
        lanes[0].ctrlChar && lanes[0].octet == CHAR_K28_5)
        else $error("no comma while sync held low");
    AST_BLK_HDR: assert property (ctrlReg[CTRL_EN_BIT] && ctrlReg[CTRL_ENC64_BIT] && quiet
        && lanes[0].header == SH_DATA |=> lanes[0].header == SH_DATA)
        else $error("block header lost");
    AST_SPARE_LANE: assert property (quiet && ctrlReg[16:12] < 5'h10 |-> lanes[15] == 11'h000)
        else $error("unused lane not idle");
    cover property (lanes[0].ctrlChar && lanes[0].octet == CHAR_K28_0);
    cover property (ncoSyncTrig);
    cover property (outWord.valid && outWord.complexOut);
endmodule // ddcl_front_properties

bind ddcl_front ddcl_front_properties u_props (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .sampleIn(sampleIn), .sampleValid(sampleValid), .syncN(syncN), .outWord(outWord),
    .lanes(lanes), .fecOn(fecOn), .ncoSyncTrig(ncoSyncTrig));

// file: dv/ddcl_rx_model.sv
// Behavioural receiving logic device watching lane 0.
// Assumes lane octets are pre-coding characters with a control flag.
`timescale 1ns/1ns
module ddcl_rx_model (
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 linkReq,
    input wire ddcl_pkg::ddcl_lane_t laneIn,
    output logic                     syncN,
    output logic                     ilasSeen
);
    import ddcl_pkg::*;
    logic [2:0] commaCnt;
    always @(posedge mclk) begin
        if (rst || !linkReq || !(laneIn.ctrlChar && laneIn.octet == CHAR_K28_5))
            commaCnt <= (commaCnt == 3'h4 && linkReq && !rst) ? commaCnt : 3'h0;
        else if (commaCnt != 3'h4)
            commaCnt <= commaCnt + 3'h1;
        ilasSeen <= !rst && linkReq && (ilasSeen || (laneIn.ctrlChar && laneIn.octet == CHAR_K28_0));
    end
    // Lock after four commas; no wait for the receiver's own multiframe edge
    assign syncN = !(linkReq && commaCnt != 3'h4);
endmodule // ddcl_rx_model

// file: dv/ddcl_front_bench.sv
// Self-checking bench for ddcl_front with a receiver model on lane 0.
// Assumes zero-wait APB and one mclk per frame.
`timescale 1ns/1ns
module ddcl_front_bench;
    import ddcl_pkg::*;
    logic        mclk, rst, psel, penable, pwrite, sampleValid, sysref, linkReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, fecOn, ncoSyncTrig, syncN, ilasSeen, errSeen;
    ddcl_iq_t    sampleIn;
    ddcl_out_t   outWord;
    ddcl_lane_t  lanes [LANES_MAX];
    int          badCount = 0;
    int          numChecks = 0;
    ddcl_front DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sampleIn(sampleIn), .sampleValid(sampleValid), .syncN(syncN), .sysref(sysref),
        .outWord(outWord), .lanes(lanes), .fecOn(fecOn), .ncoSyncTrig(ncoSyncTrig));
    ddcl_rx_model u_rx (.mclk(mclk), .rst(rst), .linkReq(linkReq), .laneIn(lanes[0]),
        .syncN(syncN), .ilasSeen(ilasSeen));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic endSim;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic doReset;
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic waitIlas;
        int n;
        n = 0;
        while (ilasSeen !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic testRegs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", CTRL_RESET, rd);
        apb(1'b0, ADDR_FRAME, 32'h0);
        chk("frame reset", {24'h0, FRAME_RESET}, rd);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped error", 32'h1, {31'h0, errSeen});
    endtask
    task automatic sendDec(input logic [2:0] mode, input logic boost, input int n,
                           input logic [15:0] ei, input logic [15:0] eq, input logic ec);
        doReset;
        apb(1'b1, ADDR_CTRL, {27'h0, boost, 1'b0, mode});
        repeat (8) @(posedge mclk);
        // Outputs read at an edge are those launched by the edge before
        for (int k = 0; k <= n; k++) begin
            sampleIn <= '{16'h1000, 16'hF000, k == n - 1, 1'b0};
            sampleValid <= (k < n);
            @(posedge mclk);
            chk("valid", {31'h0, k == n}, {31'h0, outWord.valid});
        end
        chk("iWord", {16'h0, ei}, {16'h0, outWord.iWord});
        chk("qWord", {16'h0, eq}, {16'h0, outWord.qWord});
        chk("complexOut", {31'h0, ec}, {31'h0, outWord.complexOut});
    endtask
    task automatic testLink8;
        doReset;
        apb(1'b1, ADDR_FRAME, 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h0000_4100);
        for (int r = 0; r < 2; r++) begin
            linkReq <= 1'b0;
            repeat (2) @(posedge mclk);
            linkReq <= 1'b1;
            repeat (5) @(posedge mclk);
            chk("comma", {24'h0, CHAR_K28_5}, {24'h0, lanes[3].octet});
            waitIlas;
            chk("ilas start", 32'h1, {31'h0, ilasSeen});
        end
        repeat (30) @(posedge mclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("data state", 32'h4, {29'h0, rd[2:0]});
        chk("spare lane", 32'h0, {21'h0, lanes[9]});
        linkReq <= 1'b0;
    endtask
    task automatic testLink64;
        int hit;
        hit = 0;
        doReset;
        apb(1'b1, ADDR_FRAME, 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h0000_41E0);
        chk("fecOn", 32'h1, {31'h0, fecOn});
        repeat (12) @(posedge mclk);
        chk("header", {30'h0, SH_DATA}, {30'h0, lanes[2].header});
        linkReq <= 1'b1;
        repeat (8) begin
            @(posedge mclk);
            hit += (ncoSyncTrig === 1'b1);
        end
        chk("nco pulses", 32'h1, hit);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("block state", 32'h6, {29'h0, rd[2:0]});
        linkReq <= 1'b0;
    endtask
    task automatic testSysref;
        doReset;
        apb(1'b1, ADDR_FRAME, 32'hFF);
        repeat (10) @(posedge mclk);
        sysref <= 1'b1;
        repeat (2) @(posedge mclk);
        sysref <= 1'b0;
        repeat (6) @(posedge mclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("counter phase", 32'h5, {27'h0, rd[9:5]});
    endtask
    initial begin
        {rst, psel, penable, pwrite, sampleValid, sysref, linkReq} = 7'h40;
        paddr = 12'h000;
        pwdata = 32'h0;
        sampleIn = '0;
        doReset;
        testRegs;
        sendDec(3'h0, 1'b0, 1, 16'h1001, 16'h0000, 1'b0);
        sendDec(3'h7, 1'b0, 1, 16'h1001, 16'h0000, 1'b0);
        // Boost only in DEC4 and DEC16, two of the decimating modes, where the filters drop the image
        for (int m = 1; m < 5; m++)
            sendDec(3'(m), m[0], 4 << (m - 1), m[0] ? 16'h2001 : 16'h1001,
                    m[0] ? 16'hE000 : 16'hF000, 1'b1);
        testLink8;
        testLink64;
        testSysref;
        endSim;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        badCount++;
        endSim;
    end
endmodule // ddcl_front_bench
